// ### rtl/fmc_config_reg.sv
// Behaviour
// - only bits 12:5 store; others read zero
// - margin field selects normal, programmed, erased
// - margin stays applied during signature reads
// - lock set by one, cleared only by reset
// - lock blocks protection register writes
// - bit 9 enables protection violation interrupt
// - bit 8 enables access error interrupt
// - bit 7 enables buffer empty interrupt
// - bit 6 enables command complete interrupt
// - key bit writable only when key field 10
// - key bit steers flash writes to keys
// - key field enables backdoor only at 10
module fmc_config_reg
  import fmc_pkg::*;
(
  input wire logic clk,
  input wire logic rst_n,
  input wire fmc_bus_s bus,
  output logic [15:0] rdata,
  input wire logic [1:0] backdoor_key_enable_field,
  input wire fmc_flags_s flags,
  input wire logic signature_active,
  input wire logic flash_write,
  input wire logic protect_reg_write,
  output logic protect_reg_write_ok,
  output logic [1:0] read_margin_select,
  output logic [1:0] array_read_margin,
  output logic write_lock,
  output logic backdoor_key_write_enable,
  output logic flash_write_is_key,
  output logic flash_write_is_cmd,
  output logic irq
);

  logic [1:0] margin;
  logic [3:0] irq_en;
  logic key_open;
  logic [3:0] flag_vec;
  logic [3:0] req_vec;

  // Key field decode
  // key field decode
  assign key_open = (backdoor_key_enable_field == FMC_KEY_ENABLED);

  // Margin field, freely written
  always_ff @(posedge clk)
  begin
    if (!rst_n)
      margin <= FMC_RESET_VALUE[FMC_MARGIN_HI:FMC_MARGIN_LO];
    else if (bus.wr)
      margin <= bus.wdata[FMC_MARGIN_HI:FMC_MARGIN_LO];
  end

  // Sticky write lock
  always_ff @(posedge clk)
  begin
    if (!rst_n)
      write_lock <= FMC_RESET_VALUE[FMC_LOCK_BIT];
    else if (bus.wr && bus.wdata[FMC_LOCK_BIT])
      write_lock <= 1'b1;
  end

  // Interrupt enables, order pv, ae, cbe, cc
  always_ff @(posedge clk)
  begin
    if (!rst_n)
      irq_en <= FMC_RESET_VALUE[FMC_PV_IE_BIT:FMC_CC_IE_BIT];
    else if (bus.wr)
      irq_en <= bus.wdata[FMC_PV_IE_BIT:FMC_CC_IE_BIT];
  end

  // Key-write enable, gated by key field
  always_ff @(posedge clk)
  begin
    if (!rst_n)
      backdoor_key_write_enable <= FMC_RESET_VALUE[FMC_KEY_BIT];
    else if (bus.wr && key_open)
      backdoor_key_write_enable <= bus.wdata[FMC_KEY_BIT];
  end

  // Read back, unused bits zero
  always_comb
  begin
    rdata = 16'h0000;
    rdata[FMC_MARGIN_HI:FMC_MARGIN_LO] = margin;
    rdata[FMC_LOCK_BIT] = write_lock;
    rdata[FMC_PV_IE_BIT:FMC_CC_IE_BIT] = irq_en;
    rdata[FMC_KEY_BIT] = backdoor_key_write_enable;
  end

  // Margin to the array, also during signature
  assign read_margin_select = margin;
  assign array_read_margin = margin;

  assign protect_reg_write_ok = protect_reg_write & ~write_lock;

  assign flash_write_is_key = flash_write & backdoor_key_write_enable;
  assign flash_write_is_cmd = flash_write & ~backdoor_key_write_enable;

  // Flag and request vectors
  assign flag_vec = {flags.protection_violation_flag,
                     flags.access_error_flag,
                     flags.cmd_buffer_empty_flag,
                     flags.cmd_complete_flag};

  // One gate per source
  genvar gi;
  generate
    for (gi = 0; gi < FMC_NUM_IRQ; gi++)
    begin : g_irq
      fmc_irq_gate u_gate (
        .flag(flag_vec[gi]),
        .enable(irq_en[gi]),
        .request(req_vec[gi])
      );
    end
  endgenerate

  assign irq = |req_vec;

  // Assertions
  sequence s_write_zero_lock;
    bus.wr && !bus.wdata[FMC_LOCK_BIT];
  endsequence

  sequence s_locked;
    write_lock;
  endsequence

  lock_sticky_a: assert property (@(posedge clk) disable iff (!rst_n)
    s_locked ##0 s_write_zero_lock |=> write_lock)
    else $error("lock cleared by write");

  lock_set_a: assert property (@(posedge clk) disable iff (!rst_n)
    bus.wr && bus.wdata[FMC_LOCK_BIT] |=> write_lock)
    else $error("lock not set");

  lock_block_a: assert property (@(posedge clk) disable iff (!rst_n)
    write_lock |-> !protect_reg_write_ok)
    else $error("protected write passed while locked");

  key_ignore_a: assert property (@(posedge clk) disable iff (!rst_n)
    bus.wr && !key_open |=> $stable(backdoor_key_write_enable))
    else $error("key bit written while key field closed");

  key_write_a: assert property (@(posedge clk) disable iff (!rst_n)
    bus.wr && key_open |=>
      backdoor_key_write_enable == $past(bus.wdata[FMC_KEY_BIT]))
    else $error("key bit write lost");

  margin_store_a: assert property (@(posedge clk) disable iff (!rst_n)
    bus.wr |=> array_read_margin ==
      $past(bus.wdata[FMC_MARGIN_HI:FMC_MARGIN_LO]))
    else $error("margin not stored");

  margin_sig_a: assert property (@(posedge clk) disable iff (!rst_n)
    signature_active && !bus.wr |=> $stable(array_read_margin))
    else $error("margin changed during signature");

  reserved_zero_a: assert property (@(posedge clk) disable iff (!rst_n)
    rdata[15:13] == 3'h0 && rdata[4:0] == 5'h00)
    else $error("reserved bits not zero");

  pv_irq_a: assert property (@(posedge clk) disable iff (!rst_n)
    flags.protection_violation_flag && rdata[FMC_PV_IE_BIT] |-> irq)
    else $error("pv interrupt missing");

  cc_irq_a: assert property (@(posedge clk) disable iff (!rst_n)
    flags.cmd_complete_flag && rdata[FMC_CC_IE_BIT] |-> irq)
    else $error("cc interrupt missing");

  ae_irq_a: assert property (@(posedge clk) disable iff (!rst_n)
    flags.access_error_flag && rdata[FMC_AE_IE_BIT] |-> irq)
    else $error("ae interrupt missing");

  cbe_irq_a: assert property (@(posedge clk) disable iff (!rst_n)
    flags.cmd_buffer_empty_flag && rdata[FMC_CBE_IE_BIT] |-> irq)
    else $error("cbe interrupt missing");

  irq_quiet_a: assert property (@(posedge clk) disable iff (!rst_n)
    (rdata[9:6] & flag_vec) == 4'h0 |-> !irq)
    else $error("spurious interrupt");

  steer_a: assert property (@(posedge clk) disable iff (!rst_n)
    flash_write |-> flash_write_is_key != flash_write_is_cmd)
    else $error("flash write steering wrong");

  steer_idle_a: assert property (@(posedge clk) disable iff (!rst_n)
    !flash_write |-> !flash_write_is_key && !flash_write_is_cmd)
    else $error("steering active without flash write");

  protect_pass_a: assert property (@(posedge clk) disable iff (!rst_n)
    !write_lock && protect_reg_write |-> protect_reg_write_ok)
    else $error("protected write refused while unlocked");

  enable_store_a: assert property (@(posedge clk) disable iff (!rst_n)
    bus.wr |=> rdata[FMC_PV_IE_BIT:FMC_CC_IE_BIT] ==
      $past(bus.wdata[FMC_PV_IE_BIT:FMC_CC_IE_BIT]))
    else $error("interrupt enables not stored");

  reset_clear_a: assert property (@(posedge clk)
    !rst_n |=> rdata == FMC_RESET_VALUE)
    else $error("register not cleared by reset");

endmodule : fmc_config_reg

// ### rtl/fmc_pkg.sv
package fmc_pkg;
  // Register layout, 16-bit configuration register
  localparam int FMC_WIDTH = 16;
  localparam int FMC_MARGIN_HI = 12;
  localparam int FMC_MARGIN_LO = 11;
  localparam int FMC_LOCK_BIT = 10;
  localparam int FMC_PV_IE_BIT = 9;
  localparam int FMC_AE_IE_BIT = 8;
  localparam int FMC_CBE_IE_BIT = 7;
  localparam int FMC_CC_IE_BIT = 6;
  localparam int FMC_KEY_BIT = 5;
  localparam logic [15:0] FMC_RESET_VALUE = 16'h0000;
  localparam logic [1:0] FMC_KEY_ENABLED = 2'h2;
  localparam int FMC_NUM_IRQ = 4;

  // Read margin encodings
  typedef enum logic [1:0] {
    FMC_MARGIN_NORMAL = 2'h0,
    FMC_MARGIN_PROGRAMMED = 2'h1,
    FMC_MARGIN_ERASED = 2'h2,
    FMC_MARGIN_RESERVED = 2'h3
  } fmc_margin_e;

  // Status flags from the user status register
  typedef struct packed {
    logic protection_violation_flag;
    logic access_error_flag;
    logic cmd_buffer_empty_flag;
    logic cmd_complete_flag;
  } fmc_flags_s;

  // Register bus request
  typedef struct packed {
    logic wr;
    logic [15:0] wdata;
  } fmc_bus_s;
endpackage : fmc_pkg

// ### rtl/fmc_irq_gate.sv
module fmc_irq_gate
  import fmc_pkg::*;
(
  input wire logic flag,
  input wire logic enable,
  output logic request
);
  // Flag qualified by its enable
  assign request = flag & enable;
endmodule : fmc_irq_gate

// ### test/fmc_cpu_model.sv
module fmc_cpu_model
  import fmc_pkg::*;
(
  input wire logic clk,
  input wire logic req,
  input wire logic [15:0] req_data,
  output fmc_bus_s bus
);
  timeunit 1ns;
  timeprecision 1ps;
  // One-cycle write strobe; data inverted while idle
  always_ff @(posedge clk)
  begin
    bus.wr <= req;
    bus.wdata <= req ? req_data : ~req_data;
  end
endmodule : fmc_cpu_model

// ### test/fmc_config_reg_bench.sv
module fmc_config_reg_bench
  import fmc_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk = 0, rst_n = 0, req = 0, sig = 0;
  logic [15:0] req_data = 16'h0000, rdata, e;
  logic [1:0] key = 2'h0, rms, arm;
  logic lock, kwe, is_key, is_cmd, irq, ok;
  logic fw = 1'b1, pw = 1'b1;
  fmc_flags_s flags = '0;
  fmc_bus_s bus;
  int n_errors = 0;
  int n_checks = 0;
  // Key field, write word, expected read value
  logic [33:0] rows [7] = '{{2'h0, 16'hFBFF, 16'h1BC0},
    {2'h2, 16'h0020, 16'h0020}, {2'h3, 16'h0000, 16'h0020},
    {2'h1, 16'h0800, 16'h0820}, {2'h2, 16'h1000, 16'h1000},
    {2'h0, 16'h0400, 16'h0400}, {2'h0, 16'h0000, 16'h0400}};

  fmc_cpu_model cpu (.clk(clk), .req(req), .req_data(req_data), .bus(bus));

  fmc_config_reg uut (.clk(clk), .rst_n(rst_n), .bus(bus), .rdata(rdata),
    .backdoor_key_enable_field(key), .flags(flags),
    .signature_active(sig), .flash_write(fw), .protect_reg_write(pw),
    .protect_reg_write_ok(ok), .read_margin_select(rms),
    .array_read_margin(arm), .write_lock(lock),
    .backdoor_key_write_enable(kwe), .flash_write_is_key(is_key),
    .flash_write_is_cmd(is_cmd), .irq(irq));

  task automatic chk(input string nm, input logic [15:0] got, exp);
    n_checks++;
    if (got !== exp)
    begin
      n_errors++;
      $display("[FAIL] %s expected %h seen %h", nm, exp, got);
    end
  endtask : chk

  // Write through the model, then let the register settle
  task automatic wr(input logic [15:0] d);
    req <= 1'b1;
    req_data <= d;
    @(posedge clk);
    req <= 1'b0;
    repeat (3) @(posedge clk);
  endtask : wr

  task automatic tally_and_finish;
    $display("%0d checks, %0d mismatches", n_checks, n_errors);
    if (n_errors == 0 && n_checks > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask : tally_and_finish

  // Clock, 4 ns period
  initial
  begin
    forever #2 clk = ~clk;
  end

  // Watchdog, about ten times the expected run
  initial
  begin
    repeat (800) @(posedge clk);
    n_errors++;
    tally_and_finish();
  end

  // Main sequence
  initial
  begin
    repeat (10) @(posedge clk);
    rst_n <= 1'b1;
    foreach (rows[i])
    begin
      key <= rows[i][33:32];
      sig <= i[0];
      wr(rows[i][31:16]);
      e = rows[i][15:0];
      chk("rdata", rdata, e);
      chk("outs", 16'({arm, rms, lock, kwe, is_key, is_cmd, ok}),
        16'({e[12:11], e[12:11], e[10], e[5], e[5], !e[5], !e[10]}));
      $display("row %0d done", i);
    end
    rst_n <= 1'b0;
    repeat (2) @(posedge clk);
    chk("reset rdata", rdata, FMC_RESET_VALUE);
    chk("reset outs", 16'({lock, ok}), 16'h0001);
    rst_n <= 1'b1;
    $display("reset test done");
    for (int i = 0; i < 4; i++)
    begin
      wr(16'h0200 >> i);
      flags <= 4'h8 >> i;
      @(posedge clk);
      chk("irq on", 16'(irq), 16'h0001);
      flags <= ~(4'h8 >> i);
      @(posedge clk);
      chk("irq off", 16'(irq), 16'h0000);
    end
    $display("irq test done");
    // Idle flash and protection ports with key bit set
    key <= 2'h2;
    fw <= 1'b0;
    pw <= 1'b0;
    wr(16'h0020);
    chk("idle", 16'({kwe, is_key, is_cmd, ok}), 16'h0008);
    fw <= 1'b1;
    @(posedge clk);
    chk("key steer", 16'({is_key, is_cmd}), 16'h0002);
    $display("idle test done");
    tally_and_finish();
  end
endmodule : fmc_config_reg_bench
